/* File: hw/sbns_pkg.sv */
// sbns_pkg: constants, register map and state type of the subtract/swap core
// assumes: shared by the core top, its operand resolver and its arithmetic unit
package sbns_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FADDR_W = 12;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int FLAG_W = 5;
  localparam int MEM_DEPTH = 4096;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WREG = 8'h0c;
  localparam logic [7:0] OFS_BANK = 8'h10;
  localparam logic [7:0] OFS_INDEX = 8'h14;
  localparam logic [7:0] OFS_MADDR = 8'h18;
  localparam logic [7:0] OFS_MDATA = 8'h1c;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int STAT_BUSY = 8;
  localparam int STAT_BAD = 9;
  localparam int CTRL_EXT = 0;
  localparam int INS_A = 8;
  localparam int INS_D = 9;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] INDEX_RST = 12'h000;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // ----------------------------------------------------------------
  // opcodes and addressing
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_SUB = 6'b010110;
  localparam logic [5:0] OPC_SWAP = 6'b001110;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1 = 5'b00010,
    ST_Q2 = 5'b00100,
    ST_Q3 = 5'b01000,
    ST_Q4 = 5'b10000
  } sbns_state_t;

  function automatic logic is_sub(input logic [15:0] op);
    return op[15:10] == OPC_SUB;
  endfunction : is_sub

  function automatic logic is_swap(input logic [15:0] op);
    return op[15:10] == OPC_SWAP;
  endfunction : is_swap

  // byte-lane merge of a bus write into an existing register value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

endpackage : sbns_pkg

/* File: hw/sbns_alu_if.sv */
// sbns_alu_if: operands and results between core sequencer and arithmetic unit
// assumes: purely combinational traffic within one clock
`timescale 1ns/100ps
interface sbns_alu_if;
  logic [7:0] opd_f;
  logic [7:0] opd_w;
  logic carry_in;
  logic op_swap;
  logic [7:0] result;
  logic [4:0] flags;
  modport core (output opd_f, output opd_w, output carry_in, output op_swap,
                input result, input flags);
  modport alu (input opd_f, input opd_w, input carry_in, input op_swap,
               output result, output flags);
endinterface : sbns_alu_if

/* File: hw/sbns_alu.sv */
// sbns_alu: subtract-with-borrow and nibble exchange datapath
// assumes: operands held stable by the sequencer during the process quarter
`timescale 1ns/100ps
module sbns_alu (
  sbns_alu_if.alu io
);
  import sbns_pkg::*;

  logic [8:0] full;
  logic [4:0] half;

  always_comb begin
    // f + ~w + c is f - w - !c; bit 8 set means no borrow
    full = {1'b0, io.opd_f} + {1'b0, ~io.opd_w} + {8'h00, io.carry_in};
    half = {1'b0, io.opd_f[3:0]} + {1'b0, ~io.opd_w[3:0]} + {4'h0, io.carry_in};
    io.flags = '0;
    if (io.op_swap) begin
      io.result = {io.opd_f[3:0], io.opd_f[7:4]};
    end else begin
      io.result = full[7:0];
      io.flags[FLG_C] = full[8];
      io.flags[FLG_DC] = half[4];
      io.flags[FLG_Z] = (full[7:0] == 8'h00);
      io.flags[FLG_OV] = (io.opd_f[7] ^ io.opd_w[7]) & (io.opd_f[7] ^ full[7]);
      io.flags[FLG_N] = full[7];
    end
  end

endmodule : sbns_alu

/* File: hw/sbns_addr_res.sv */
// sbns_addr_res: resolves the 8-bit file field into a 12-bit data address
// assumes: combinational, inputs stable for the read quarter
`timescale 1ns/100ps
module sbns_addr_res (
  input wire logic [7:0] f,
  input wire logic a,
  input wire logic ext,
  input wire logic [3:0] bank,
  input wire logic [11:0] index,
  output logic [11:0] addr,
  output logic indexed
);
  import sbns_pkg::*;

  always_comb begin
    indexed = !a && ext && (f <= IDX_LIMIT);
    if (a) begin
      addr = {bank, f};
    end else if (indexed) begin
      addr = 12'(index + {4'h0, f});
    end else if (f <= IDX_LIMIT) begin
      addr = {ACC_LO_BANK, f};
    end else begin
      addr = {ACC_HI_BANK, f};
    end
  end

endmodule : sbns_addr_res

/* File: hw/sbns_core.sv */
// sbns_core: executes subtract-with-borrow and nibble exchange on a file memory
// assumes: AXI4-Lite master on CORE_CLK, one write and one read outstanding at most
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module sbns_core (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [sbns_pkg::AXI_AW-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [sbns_pkg::AXI_DW-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [sbns_pkg::AXI_AW-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [sbns_pkg::AXI_DW-1:0] RDATA,
  output logic [1:0] RRESP
);
  import sbns_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sbns_state_t state_q;
  logic [7:0] mem [MEM_DEPTH];
  logic ext_q;
  logic [15:0] instr_q;
  logic [FLAG_W-1:0] flags_q;
  logic bad_q;
  logic [7:0] wreg_q;
  logic [3:0] bank_q;
  logic [11:0] index_q;
  logic [11:0] maddr_q;
  logic op_sub_q;
  logic op_swap_q;
  logic dest_q;
  logic [11:0] faddr_q;
  logic [7:0] opd_q;
  logic [7:0] res_q;
  logic [FLAG_W-1:0] rflg_q;
  logic [11:0] addr_c;
  logic indexed_c;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic wr_ok;
  logic busy;
  logic [31:0] rd_c;
  logic rd_hit;
  logic [31:0] old_c;
  logic [31:0] new_c;

  assign busy = (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // operand address and arithmetic
  // ----------------------------------------------------------------
  sbns_addr_res u_res (
    .f(instr_q[7:0]),
    .a(instr_q[INS_A]),
    .ext(ext_q),
    .bank(bank_q),
    .index(index_q),
    .addr(addr_c),
    .indexed(indexed_c)
  );

  sbns_alu_if alu_bus ();
  assign alu_bus.opd_f = opd_q;
  assign alu_bus.opd_w = wreg_q;
  assign alu_bus.carry_in = flags_q[FLG_C];
  assign alu_bus.op_swap = op_swap_q;

  sbns_alu u_alu (
    .io(alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // bus write channels
  // ----------------------------------------------------------------
  // address and data are taken in either order; the write acts once both are held
  assign wr_go = aw_full_q && w_full_q && !BVALID;
  // writes while an instruction runs are refused so the quarters see stable operands
  assign wr_ok = !busy && (awaddr_q <= OFS_MDATA) && (awaddr_q[1:0] == 2'b00);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (AWVALID && !aw_full_q) begin
      aw_full_q <= 1'b1;
      awaddr_q <= AWADDR;
    end else if (BVALID && BREADY) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (WVALID && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end else if (BVALID && BREADY) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
    end else begin
      AWREADY <= !(aw_full_q || (AWVALID && AWREADY)) || (BVALID && BREADY);
      WREADY <= !(w_full_q || (WVALID && WREADY)) || (BVALID && BREADY);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // current value of the addressed register, so a narrow strobe keeps the other lanes
  always_comb begin
    old_c = 32'h0000_0000;
    unique case (awaddr_q)
      OFS_CTRL: old_c[CTRL_EXT] = ext_q;
      OFS_INSTR: old_c[15:0] = instr_q;
      OFS_STATUS: old_c[FLAG_W-1:0] = flags_q;
      OFS_WREG: old_c[7:0] = wreg_q;
      OFS_BANK: old_c[3:0] = bank_q;
      OFS_INDEX: old_c[11:0] = index_q;
      OFS_MADDR: old_c[11:0] = maddr_q;
      default: ;
    endcase
    new_c = wmerge(old_c, wdata_q, wstrb_q);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ext_q <= 1'b0;
      bank_q <= BANK_RST;
      index_q <= INDEX_RST;
      maddr_q <= 12'h000;
    end else if (wr_go && wr_ok) begin
      unique case (awaddr_q)
        OFS_CTRL: ext_q <= new_c[CTRL_EXT];
        OFS_BANK: bank_q <= new_c[3:0];
        OFS_INDEX: index_q <= new_c[11:0];
        OFS_MADDR: maddr_q <= new_c[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      instr_q <= INSTR_RST;
    end else if (wr_go && wr_ok && awaddr_q == OFS_INSTR) begin
      instr_q <= new_c[15:0];
    end
  end

  // ----------------------------------------------------------------
  // quarter sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (wr_go && wr_ok && awaddr_q == OFS_INSTR) state_q <= ST_Q1;
        ST_Q1: state_q <= ST_Q2;
        ST_Q2: state_q <= ST_Q3;
        ST_Q3: state_q <= ST_Q4;
        ST_Q4: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      op_sub_q <= 1'b0;
      op_swap_q <= 1'b0;
      dest_q <= 1'b1;
      bad_q <= 1'b0;
    end else if (state_q == ST_Q1) begin
      op_sub_q <= is_sub(instr_q);
      op_swap_q <= is_swap(instr_q);
      dest_q <= instr_q[INS_D];
      // anything else is left untouched and reported
      bad_q <= !is_sub(instr_q) && !is_swap(instr_q);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      faddr_q <= 12'h000;
      opd_q <= 8'h00;
      res_q <= 8'h00;
      rflg_q <= FLAGS_RST;
    end else if (state_q == ST_Q2) begin
      faddr_q <= addr_c;
      opd_q <= mem[addr_c];
    end else if (state_q == ST_Q3) begin
      res_q <= alu_bus.result;
      rflg_q <= alu_bus.flags;
    end
  end

  // ----------------------------------------------------------------
  // destination write and flags
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (state_q == ST_Q4 && (op_sub_q || op_swap_q) && dest_q) begin
      mem[faddr_q] <= res_q;
    end else if (wr_go && wr_ok && awaddr_q == OFS_MDATA && wstrb_q[0]) begin
      mem[maddr_q] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wreg_q <= WREG_RST;
    end else if (state_q == ST_Q4 && (op_sub_q || op_swap_q) && !dest_q) begin
      wreg_q <= res_q;
    end else if (wr_go && wr_ok && awaddr_q == OFS_WREG) begin
      wreg_q <= new_c[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_q <= FLAGS_RST;
    end else if (state_q == ST_Q4 && op_sub_q) begin
      flags_q <= rflg_q;
    end else if (wr_go && wr_ok && awaddr_q == OFS_STATUS) begin
      flags_q <= new_c[FLAG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_c = 32'h0000_0000;
    unique case (ARADDR)
      OFS_CTRL: rd_c[CTRL_EXT] = ext_q;
      OFS_INSTR: rd_c[15:0] = instr_q;
      OFS_STATUS: begin
        rd_c[FLAG_W-1:0] = flags_q;
        rd_c[STAT_BUSY] = busy;
        rd_c[STAT_BAD] = bad_q;
      end
      OFS_WREG: rd_c[7:0] = wreg_q;
      OFS_BANK: rd_c[3:0] = bank_q;
      OFS_INDEX: rd_c[11:0] = index_q;
      OFS_MADDR: rd_c[11:0] = maddr_q;
      OFS_MDATA: rd_c[7:0] = mem[maddr_q];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_c;
      RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_sub_math: assert property (
    state_q == ST_Q3 && op_sub_q |=>
      res_q == 8'($past(opd_q) - $past(wreg_q) - {7'h00, !$past(flags_q[FLG_C])}))
    else $error("subtract result wrong");
  a_sub_decode: assert property (
    state_q == ST_Q1 && instr_q[15:10] == 6'b010110 |=> op_sub_q && !op_swap_q)
    else $error("subtract opcode not decoded");
  a_dest_wreg: assert property (
    state_q == ST_Q4 && op_sub_q && !dest_q |=> wreg_q == $past(res_q))
    else $error("accumulator not written");
  a_dest_file: assert property (
    state_q == ST_Q4 && op_swap_q && dest_q |=> mem[$past(faddr_q)] == $past(res_q))
    else $error("file not written");
  a_access_bank: assert property (
    state_q == ST_Q2 && !instr_q[INS_A] && !ext_q |->
      addr_c[11:8] == (instr_q[7:0] <= 8'h5f ? 4'h0 : 4'hf) && addr_c[7:0] == instr_q[7:0])
    else $error("access bank address wrong");
  a_bank_ptr: assert property (
    state_q == ST_Q2 && instr_q[INS_A] |=> faddr_q == {$past(bank_q), $past(instr_q[7:0])})
    else $error("bank pointer not used");
  a_indexed: assert property (
    state_q == ST_Q2 && !instr_q[INS_A] && ext_q && instr_q[7:0] <= 8'h5f |->
      addr_c == 12'(index_q + {4'h0, instr_q[7:0]}))
    else $error("indexed offset wrong");
  a_zero_flag: assert property (
    state_q == ST_Q4 && op_sub_q |=> flags_q[FLG_Z] == ($past(res_q) == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (
    state_q == ST_Q4 && op_sub_q |=> flags_q[FLG_N] == $past(res_q[7]))
    else $error("negative flag wrong");
  a_swap_nibble: assert property (
    state_q == ST_Q3 && op_swap_q |=> res_q == {$past(opd_q[3:0]), $past(opd_q[7:4])}
      ##1 $stable(flags_q))
    else $error("swap wrong or flags touched");
  a_carry_flag: assert property (
    state_q == ST_Q3 && op_sub_q |=> ##1
      flags_q[FLG_C] == ({1'b0, $past(opd_q, 2)} >= {1'b0, $past(wreg_q, 2)}
        + {8'h00, !$past(flags_q[FLG_C], 2)}))
    else $error("carry flag wrong");
  a_one_cycle: assert property (
    state_q == ST_Q1 |=> state_q == ST_Q2 ##1 state_q == ST_Q3 ##1 state_q == ST_Q4
      ##1 state_q == ST_IDLE)
    else $error("instruction not four quarters");

  c_sub_to_w: cover property (state_q == ST_Q4 && op_sub_q && !dest_q);
  c_swap_to_f: cover property (state_q == ST_Q4 && op_swap_q && dest_q);
  c_indexed: cover property (state_q == ST_Q2 && indexed_c);
  c_busy_refused: cover property (wr_go && busy);

endmodule : sbns_core

/* File: test/subtract_borrow_and_nibble_swap_tb.sv */
// subtract_borrow_and_nibble_swap_tb: self-checking bench for sbns_core over AXI4-Lite
// assumes: sbns_pkg compiled first; the bench is the only bus master
`timescale 1ns/100ps
module subtract_borrow_and_nibble_swap_tb;
  import sbns_pkg::*;

  // ----------------------------------------------------------------
  // clock, reset, bus signals
  // ----------------------------------------------------------------
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [AXI_AW-1:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [AXI_DW-1:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hf;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [AXI_DW-1:0] RDATA;
  logic [31:0] v;
  logic [12:0] e;
  int n_errors = 0;
  int comparisons = 0;
  localparam logic [7:0] SF [5] = '{8'h19, 8'h1b, 8'h03, 8'h80, 8'h10};
  localparam logic [7:0] SW [5] = '{8'h0d, 8'h1a, 8'h0e, 8'h01, 8'h01};
  localparam logic SC [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic SD [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic AE [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [7:0] AF [5] = '{8'h20, 8'h80, 8'h20, 8'h50, 8'h60};
  localparam logic [11:0] AA [5] = '{12'h020, 12'hf80, 12'h000, 12'h030, 12'hf60};

  always #5 CORE_CLK = ~CORE_CLK;

  sbns_core u_dut (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic timed_out;
    n_errors++;
    $display("wrong value at %0t: handshake timeout", $time);
    close_out();
  endtask : timed_out

  // ----------------------------------------------------------------
  // bus tasks: handshakes judged on settled values, changes after the edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    @(posedge CORE_CLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= d;
    BREADY <= 1'b1;
    tb = 1'b0;
    n = 0;
    while (!tb) begin
      @(negedge CORE_CLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      tb = BVALID && BREADY;
      r = BRESP;
      n++;
      if (n > 50) timed_out();
      @(posedge CORE_CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
    check({30'h0, r}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] r;
    int n;
    @(posedge CORE_CLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    tr = 1'b0;
    n = 0;
    while (!tr) begin
      @(negedge CORE_CLK);
      ta = ARVALID && ARREADY;
      tr = RVALID && RREADY;
      r = RRESP;
      d = RDATA;
      n++;
      if (n > 50) timed_out();
      @(posedge CORE_CLK);
      if (ta) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    check({30'h0, r}, {30'h0, er}, "read response");
  endtask : rd

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(OFS_MADDR, {20'h0, a}, RESP_OKAY);
    wr(OFS_MDATA, {24'h0, d}, RESP_OKAY);
  endtask : mem_wr

  task automatic mem_rd(input logic [11:0] a, output logic [31:0] d);
    wr(OFS_MADDR, {20'h0, a}, RESP_OKAY);
    rd(OFS_MDATA, d, RESP_OKAY);
  endtask : mem_rd

  task automatic wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h0000_0100;
    while (s[STAT_BUSY] !== 1'b0) begin
      rd(OFS_STATUS, s, RESP_OKAY);
      n++;
      if (n > 20) timed_out();
    end
  endtask : wait_idle

  task automatic run(input logic [15:0] op);
    wr(OFS_INSTR, {16'h0, op}, RESP_OKAY);
    wait_idle();
  endtask : run

  // flags and difference of f - w - not c, worked out by plain 9-bit and 5-bit subtraction
  function automatic logic [12:0] sub_ref(input logic [7:0] f, input logic [7:0] w,
                                          input logic c);
    logic [8:0] r;
    logic [4:0] h;
    logic [4:0] fl;
    r = {1'b0, f} - {1'b0, w} - {8'h0, !c};
    h = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, !c};
    fl[FLG_C] = !r[8];
    fl[FLG_DC] = !h[4];
    fl[FLG_Z] = (r[7:0] == 8'h00);
    fl[FLG_OV] = (f[7] != w[7]) && (r[7] != f[7]);
    fl[FLG_N] = r[7];
    return {fl, r[7:0]};
  endfunction : sub_ref

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(8'(4 * k), v, RESP_OKAY);
      check(v, 32'h0, "reset value");
    end
    rd(8'h20, v, RESP_SLVERR);
    check(v, 32'h0, "unmapped read data");
    rd(8'h02, v, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    $display("test reset and map done");

    for (int i = 0; i < 5; i++) begin
      e = sub_ref(SF[i], SW[i], SC[i]);
      wr(OFS_BANK, 32'(i + 1), RESP_OKAY);
      wr(OFS_WREG, {24'h0, SW[i]}, RESP_OKAY);
      wr(OFS_STATUS, {31'h0, SC[i]}, RESP_OKAY);
      mem_wr({4'(i + 1), 8'h40}, SF[i]);
      run({OPC_SUB, SD[i], 1'b1, 8'h40});
      rd(OFS_WREG, v, RESP_OKAY);
      check(v, {24'h0, SD[i] ? SW[i] : e[7:0]}, "accumulator");
      mem_rd({4'(i + 1), 8'h40}, v);
      check(v, {24'h0, SD[i] ? e[7:0] : SF[i]}, "file byte");
      rd(OFS_STATUS, v, RESP_OKAY);
      check(v, {27'h0, e[12:8]}, "flags");
    end
    $display("test subtract with borrow done");

    wr(OFS_INDEX, 32'h0000_0fe0, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, {31'h0, AE[i]}, RESP_OKAY);
      wr(OFS_STATUS, 32'h0000_001f, RESP_OKAY);
      mem_wr(AA[i], {4'h5, 4'(i + 1)});
      run({OPC_SWAP, 1'b1, 1'b0, AF[i]});
      mem_rd(AA[i], v);
      check(v, {24'h0, 4'(i + 1), 4'h5}, "swapped byte");
      rd(OFS_STATUS, v, RESP_OKAY);
      check(v, 32'h0000_001f, "flags kept");
    end
    WSTRB <= 4'h2;
    wr(OFS_INDEX, 32'h0000_0abc, RESP_OKAY);
    WSTRB <= 4'hf;
    rd(OFS_INDEX, v, RESP_OKAY);
    check(v, 32'h0000_0ae0, "index with one byte lane");
    $display("test access bank and indexed swap done");

    wr(OFS_BANK, 32'h7, RESP_OKAY);
    wr(OFS_WREG, 32'h0, RESP_OKAY);
    mem_wr(12'h711, 8'ha7);
    run({OPC_SWAP, 1'b0, 1'b1, 8'h11});
    rd(OFS_WREG, v, RESP_OKAY);
    check(v, 32'h0000_007a, "swap to accumulator");
    mem_rd(12'h711, v);
    check(v, 32'h0000_00a7, "file untouched");
    run({6'b010111, 1'b0, 1'b1, 8'h11});
    rd(OFS_STATUS, v, RESP_OKAY);
    check({31'h0, v[STAT_BAD]}, 32'h1, "bad opcode flag");
    wr(OFS_WREG, 32'h0000_0033, RESP_OKAY);
    run({OPC_SWAP, 1'b0, 1'b1, 8'h11});
    rd(OFS_STATUS, v, RESP_OKAY);
    check({31'h0, v[STAT_BAD]}, 32'h0, "bad opcode cleared");
    rd(OFS_WREG, v, RESP_OKAY);
    check(v, 32'h0000_007a, "swap after bad opcode");
    $display("test opcode decode done");

    wr(OFS_INSTR, {16'h0, OPC_SWAP, 1'b0, 1'b1, 8'h11}, RESP_OKAY);
    wr(OFS_BANK, 32'h0000_0003, RESP_SLVERR);
    wait_idle();
    rd(OFS_BANK, v, RESP_OKAY);
    check(v, 32'h0000_0007, "write refused while busy");
    rd(OFS_WREG, v, RESP_OKAY);
    check(v, 32'h0000_007a, "swap result while busy");
    $display("test busy refusal done");
    close_out();
  end

endmodule : subtract_borrow_and_nibble_swap_tb
